// ### src/acir_pkg.sv
// Constants and types for the converter control and input current result
package acir_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h15;
    localparam logic [7:0] ADDR_CHAN_OFF = 8'h16;
    localparam logic [7:0] ADDR_RES_HI = 8'h17;
    localparam logic [7:0] ADDR_RES_LO = 8'h18;

    // ------------------------------------------------------------
    // Reset values and writable bits
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h30;
    localparam logic [7:0] CHAN_OFF_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0] CTRL_WR_MASK = 8'hF0;
    localparam logic [7:0] CHAN_OFF_WR_MASK = 8'hE7;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Field positions of the control register
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_RATE_BIT = 6;
    localparam int CTRL_SPEED_HI = 5;
    localparam int CTRL_SPEED_LO = 4;

    // ------------------------------------------------------------
    // Channel numbers, equal to their disable bit positions
    // ------------------------------------------------------------
    localparam logic [2:0] CH_INPUT_CURRENT = 3'h7;
    localparam logic [2:0] CH_CHARGE_CURRENT = 3'h6;
    localparam logic [2:0] CH_BUS_VOLTAGE = 3'h5;
    localparam logic [2:0] CH_BATTERY_VOLTAGE = 3'h4;
    localparam logic [2:0] CH_THERMISTOR = 3'h2;
    localparam logic [2:0] CH_CELL_VOLTAGE = 3'h1;
    localparam logic [2:0] CH_DIE_TEMP = 3'h0;
    localparam logic [2:0] CH_FIRST = 3'h7;
    localparam logic [2:0] CH_LAST = 3'h0;

    // ------------------------------------------------------------
    // Resolution and result scaling
    // ------------------------------------------------------------
    localparam logic [3:0] RES_BITS_MAX = 4'hF;
    localparam logic signed [15:0] RESULT_RANGE_MA = 16'sh0FA0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SCAN = 2'b01,
        SEQ_WAIT = 2'b10
    } acir_seq_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } acir_reg_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } acir_reg_rsp_t;

    typedef struct packed {
        logic start;
        logic [2:0] chan;
        logic [3:0] res_bits;
    } acir_conv_cmd_t;

endpackage

// ### src/acir_seq.sv
// Channel sequencer that steps the converter through enabled channels
`timescale 1ns/1ps

module acir_seq (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control from the register file
    input wire logic run_i,
    input wire logic one_shot_i,
    input wire logic [7:0] chan_on_i,
    // Converter handshake
    input wire logic conv_done_i,
    output logic conv_start_o,
    output logic [2:0] conv_chan_o,
    // Status
    output logic sample_take_o,
    output logic round_done_o,
    output logic busy_o
);

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    acir_pkg::acir_seq_state_t state_q, state_d;
    logic [2:0] ptr_q, ptr_d;
    logic step;

    // Next state: scan channels from the top bit down to bit zero
    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        conv_start_o = 1'b0;
        sample_take_o = 1'b0;
        round_done_o = 1'b0;
        step = 1'b0;
        unique case (state_q)
            acir_pkg::SEQ_IDLE: begin
                if (run_i) begin // [R1]
                    state_d = acir_pkg::SEQ_SCAN;
                    ptr_d = acir_pkg::CH_FIRST;
                end
            end
            acir_pkg::SEQ_SCAN: begin
                if (!run_i) begin // [R1]
                    state_d = acir_pkg::SEQ_IDLE;
                end else if (chan_on_i[ptr_q]) begin // [R6]
                    conv_start_o = 1'b1;
                    state_d = acir_pkg::SEQ_WAIT;
                end else begin
                    step = 1'b1; // [R6]
                end
            end
            acir_pkg::SEQ_WAIT: begin
                if (!run_i) begin // [R1]
                    state_d = acir_pkg::SEQ_IDLE;
                end else if (conv_done_i) begin
                    sample_take_o = 1'b1;
                    step = 1'b1;
                end
            end
            default: begin
                state_d = acir_pkg::SEQ_IDLE;
            end
        endcase
        // Advance to the next channel or finish the round
        if (step) begin
            if (ptr_q == acir_pkg::CH_LAST) begin
                round_done_o = 1'b1;
                ptr_d = acir_pkg::CH_FIRST;
                if (one_shot_i) begin // [R2] [R13]
                    state_d = acir_pkg::SEQ_IDLE;
                end else begin
                    state_d = acir_pkg::SEQ_SCAN; // [R2]
                end
            end else begin
                ptr_d = ptr_q - 3'h1;
                state_d = acir_pkg::SEQ_SCAN;
            end
        end
    end

    // State registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= acir_pkg::SEQ_IDLE;
            ptr_q <= acir_pkg::CH_FIRST;
        end else begin
            state_q <= state_d;
            ptr_q <= ptr_d;
        end
    end

    // Status outputs
    assign conv_chan_o = ptr_q;
    assign busy_o = (state_q != acir_pkg::SEQ_IDLE);

endmodule

// ### src/acir_top.sv
// Converter control registers and input current result register
`timescale 1ns/1ps

// Contract
// [R1] Master enable bit 7 runs converter; cleared by register reset and watchdog.
// [R2] Rate bit 6: zero converts continuously, one does a single round.
// [R3] Speed bits 5:4 select 15, 14, 13 or 12 bit resolution.
// [R4] Control register resets to 30h; bits 3:0 reserved.
// [R5] Reserved bits read zero and ignore writes.
// [R6] Channel disable bit zero converts that channel, one skips it.
// [R7] Battery voltage disable bit is read-only; bit 3 reserved.
// [R8] Channel disable register resets to 00h; watchdog leaves it.
// [R9] Input current result is read-only 16-bit two's complement.
// [R10] Result high byte at 17h, low at 18h, 1 mA per bit, reset zero.
// [R11] Positive result means current into the bus pin, negative out.
// [R12] Result covers zero to four amperes in magnitude.
// [R13] One-shot converts each enabled channel once, then stops.
module acir_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register reset and watchdog events
    input wire logic reg_rst_i,
    input wire logic wdog_expire_i,
    // Register port from the serial control interface
    input wire acir_pkg::acir_reg_req_t reg_req_i,
    output acir_pkg::acir_reg_rsp_t reg_rsp_o,
    // Converter front end
    output acir_pkg::acir_conv_cmd_t conv_cmd_o,
    input wire logic conv_done_i,
    input wire logic [15:0] conv_data_i,
    // Status
    output logic conv_running_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] chan_off_q, chan_off_d;
    logic [15:0] result_q, result_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // Sequencer wires
    logic seq_start;
    logic [2:0] seq_chan;
    logic seq_take;
    logic seq_round_done;
    logic seq_busy;
    logic run;
    logic one_shot;
    logic [7:0] chan_on;
    logic wr_ctrl;
    logic wr_chan_off;
    logic signed [15:0] sample;
    logic [15:0] clipped;

    // Decoded control fields
    assign run = ctrl_q[acir_pkg::CTRL_EN_BIT]; // [R1]
    assign one_shot = ctrl_q[acir_pkg::CTRL_RATE_BIT]; // [R2]
    // Battery channel always converts, bit 3 never does
    assign chan_on = (~chan_off_q & acir_pkg::CHAN_OFF_WR_MASK)
        | (8'h01 << acir_pkg::CH_BATTERY_VOLTAGE); // [R6] [R7]
    assign wr_ctrl = reg_req_i.we && (reg_req_i.addr == acir_pkg::ADDR_CTRL);
    assign wr_chan_off = reg_req_i.we
        && (reg_req_i.addr == acir_pkg::ADDR_CHAN_OFF);

    // ------------------------------------------------------------
    // Channel sequencer
    // ------------------------------------------------------------
    acir_seq u_seq (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(run),
        .one_shot_i(one_shot),
        .chan_on_i(chan_on),
        .conv_done_i(conv_done_i),
        .conv_start_o(seq_start),
        .conv_chan_o(seq_chan),
        .sample_take_o(seq_take),
        .round_done_o(seq_round_done),
        .busy_o(seq_busy)
    );

    // ------------------------------------------------------------
    // Result clamp to the measurement range
    // ------------------------------------------------------------
    assign sample = conv_data_i; // [R11]
    always_comb begin
        if (sample > acir_pkg::RESULT_RANGE_MA) begin // [R12]
            clipped = acir_pkg::RESULT_RANGE_MA;
        end else if (sample < -acir_pkg::RESULT_RANGE_MA) begin // [R12]
            clipped = -acir_pkg::RESULT_RANGE_MA;
        end else begin
            clipped = sample; // [R9]
        end
    end

    // ------------------------------------------------------------
    // Register file next values
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        chan_off_d = chan_off_q;
        result_d = result_q;
        // Enable drops on watchdog or at end of a single round
        if (wdog_expire_i) begin
            ctrl_d[acir_pkg::CTRL_EN_BIT] = 1'b0; // [R1]
        end
        if (seq_round_done && one_shot) begin
            ctrl_d[acir_pkg::CTRL_EN_BIT] = 1'b0; // [R13]
        end
        // Software write wins over the hardware clear
        if (wr_ctrl) begin
            ctrl_d = reg_req_i.wdata & acir_pkg::CTRL_WR_MASK; // [R5]
        end
        if (wr_chan_off) begin
            chan_off_d = reg_req_i.wdata
                & acir_pkg::CHAN_OFF_WR_MASK; // [R5] [R7]
        end
        // Capture the input current sample
        if (seq_take && (seq_chan == acir_pkg::CH_INPUT_CURRENT)) begin
            result_d = clipped; // [R9]
        end
        // Register reset restores every field
        if (reg_rst_i) begin
            ctrl_d = acir_pkg::CTRL_RESET; // [R1] [R4]
            chan_off_d = acir_pkg::CHAN_OFF_RESET; // [R8]
            result_d = acir_pkg::RESULT_RESET; // [R10]
        end
    end

    // Read data mux
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_req_i.re;
        if (reg_req_i.re) begin
            unique case (reg_req_i.addr)
                acir_pkg::ADDR_CTRL: begin
                    rdata_d = ctrl_q & acir_pkg::CTRL_WR_MASK; // [R5]
                end
                acir_pkg::ADDR_CHAN_OFF: begin
                    rdata_d = chan_off_q
                        & acir_pkg::CHAN_OFF_WR_MASK; // [R5] [R7]
                end
                acir_pkg::ADDR_RES_HI: begin
                    rdata_d = result_q[15:8]; // [R10]
                end
                acir_pkg::ADDR_RES_LO: begin
                    rdata_d = result_q[7:0]; // [R10]
                end
                default: begin
                    rdata_d = acir_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q <= acir_pkg::CTRL_RESET; // [R4]
            chan_off_q <= acir_pkg::CHAN_OFF_RESET; // [R8]
            result_q <= acir_pkg::RESULT_RESET; // [R10]
            rdata_q <= acir_pkg::READ_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            chan_off_q <= chan_off_d;
            result_q <= result_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rsp_o.rdata = rdata_q;
    assign reg_rsp_o.rvalid = rvalid_q;
    assign conv_cmd_o.start = seq_start;
    assign conv_cmd_o.chan = seq_chan;
    assign conv_cmd_o.res_bits = acir_pkg::RES_BITS_MAX
        - {2'b00, ctrl_q[acir_pkg::CTRL_SPEED_HI:acir_pkg::CTRL_SPEED_LO]};
    // [R3] resolution is 15 minus the speed code
    assign conv_running_o = seq_busy;

endmodule

// ### bench/acir_top_props.sv
// Checker for the converter control register port and sequencer
`timescale 1ns/1ps
module acir_top_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Inputs
    input wire logic reg_rst_i,
    input wire logic wdog_expire_i,
    input wire acir_pkg::acir_reg_req_t reg_req_i,
    input wire logic conv_done_i,
    input wire logic [15:0] conv_data_i,
    // Outputs
    input wire acir_pkg::acir_reg_rsp_t reg_rsp_o,
    input wire acir_pkg::acir_conv_cmd_t conv_cmd_o,
    input wire logic conv_running_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Named request steps
    sequence s_rd(a);
        reg_req_i.re && reg_req_i.addr == a;
    endsequence
    sequence s_rd_unmapped;
        reg_req_i.re && (reg_req_i.addr < acir_pkg::ADDR_CTRL
            || reg_req_i.addr > acir_pkg::ADDR_RES_LO);
    endsequence
    sequence s_wr_ctrl;
        reg_req_i.we && reg_req_i.addr == acir_pkg::ADDR_CTRL && !reg_rst_i;
    endsequence
    sequence s_wdog_clear;
        wdog_expire_i && !(reg_req_i.we
            && reg_req_i.addr == acir_pkg::ADDR_CTRL && reg_req_i.wdata[7]);
    endsequence
    // Register port answers
    a_read_answer: assert property (
        reg_req_i.re |=> reg_rsp_o.rvalid)
        else $error("read not answered next cycle");
    a_unmapped_zero: assert property (
        s_rd_unmapped |=> reg_rsp_o.rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (
        s_rd(acir_pkg::ADDR_CTRL) |=> reg_rsp_o.rdata[3:0] == 4'h0)
        else $error("control reserved bits not zero");
    a_chan_reserved: assert property (
        s_rd(acir_pkg::ADDR_CHAN_OFF)
        |=> !reg_rsp_o.rdata[3] && !reg_rsp_o.rdata[4])
        else $error("disable bits 4 or 3 not zero");
    // Resolution follows the speed field
    a_speed_map: assert property (
        s_wr_ctrl |=> conv_cmd_o.res_bits ==
        4'hF - {2'b00, $past(reg_req_i.wdata[5:4])})
        else $error("resolution does not follow speed");
    a_regrst_speed: assert property (
        reg_rst_i |=> conv_cmd_o.res_bits == 4'hC)
        else $error("register reset resolution wrong");
    // Sequencer behaviour
    a_idle_no_start: assert property (
        conv_cmd_o.start |-> conv_running_o)
        else $error("start while idle");
    a_no_chan_three: assert property (
        conv_cmd_o.start |-> conv_cmd_o.chan != 3'h3)
        else $error("channel 3 started");
    a_wdog_stop: assert property (
        s_wdog_clear |=> ##1 !conv_running_o)
        else $error("watchdog did not stop converter");
    a_regrst_stop: assert property (
        reg_rst_i |=> ##1 !conv_running_o)
        else $error("register reset did not stop converter");
endmodule

bind acir_top acir_top_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_rst_i(reg_rst_i), .wdog_expire_i(wdog_expire_i),
    .reg_req_i(reg_req_i), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .reg_rsp_o(reg_rsp_o),
    .conv_cmd_o(conv_cmd_o), .conv_running_o(conv_running_o));

// ### bench/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_rst_i = 1'b0;
    logic wdog_expire_i = 1'b0;
    logic conv_done_i = 1'b0;
    logic [15:0] conv_data_i = 16'h0000;
    acir_pkg::acir_reg_req_t req = '0;
    acir_pkg::acir_reg_rsp_t rsp;
    acir_pkg::acir_conv_cmd_t cmd;
    logic running;
    int errors = 0;
    int n_compared = 0;
    logic [2:0] order [5] = '{3'h7, 3'h5, 3'h4, 3'h2, 3'h0};

    acir_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_rst_i(reg_rst_i), .wdog_expire_i(wdog_expire_i),
        .reg_req_i(req), .reg_rsp_o(rsp), .conv_cmd_o(cmd),
        .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
        .conv_running_o(running));

    // Clock
    initial forever #12.5 clk_i = ~clk_i;

    task automatic end_sim;
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(negedge clk_i);
        req.we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        req = '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(negedge clk_i);
        req.re = 1'b0;
        chk("rvalid", 16'h0001, {15'h0000, rsp.rvalid});
        chk($sformatf("rdata at %h", a), {8'h00, e}, {8'h00, rsp.rdata});
    endtask

    // Waits for a start, checks its channel, then answers with a sample
    task automatic serve(input logic [2:0] ch, input logic [15:0] d);
        int i;
        i = 0;
        while (cmd.start !== 1'b1 && i < 40) begin
            @(negedge clk_i);
            i++;
        end
        chk("start", 16'h0001, {15'h0000, cmd.start});
        chk("chan", {13'h0000, ch}, {13'h0000, cmd.chan});
        @(negedge clk_i);
        conv_done_i = 1'b1;
        conv_data_i = d;
        @(negedge clk_i);
        conv_done_i = 1'b0;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rd(acir_pkg::ADDR_CTRL, 8'h30);
        rd(acir_pkg::ADDR_CHAN_OFF, 8'h00);
        rd(acir_pkg::ADDR_RES_HI, 8'h00);
        rd(acir_pkg::ADDR_RES_LO, 8'h00);
        rd(8'h20, 8'h00);
        wr(acir_pkg::ADDR_CTRL, 8'h0F);
        rd(acir_pkg::ADDR_CTRL, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(acir_pkg::ADDR_CTRL, 8'(s << 4));
            rd(acir_pkg::ADDR_CTRL, 8'(s << 4));
            chk("res_bits", 16'(15 - s), {12'h000, cmd.res_bits});
        end
        wr(acir_pkg::ADDR_CHAN_OFF, 8'hFF);
        rd(acir_pkg::ADDR_CHAN_OFF, 8'hE7);
        wr(acir_pkg::ADDR_RES_HI, 8'h55);
        rd(acir_pkg::ADDR_RES_HI, 8'h00);
        wr(acir_pkg::ADDR_CHAN_OFF, 8'h42);
        wr(acir_pkg::ADDR_CTRL, 8'hC0);
        for (int k = 0; k < 5; k++) begin
            serve(order[k], (k == 0) ? 16'hFB2E : 16'h0123);
        end
        repeat (4) @(negedge clk_i);
        chk("running", 16'h0000, {15'h0000, running});
        rd(acir_pkg::ADDR_CTRL, 8'h40);
        rd(acir_pkg::ADDR_RES_HI, 8'hFB);
        rd(acir_pkg::ADDR_RES_LO, 8'h2E);
        wr(acir_pkg::ADDR_CTRL, 8'h80);
        serve(3'h7, 16'h2000);
        // Stop the scan so the reads cannot swallow a start pulse
        wr(acir_pkg::ADDR_CTRL, 8'h00);
        rd(acir_pkg::ADDR_RES_HI, 8'h0F);
        rd(acir_pkg::ADDR_RES_LO, 8'hA0);
        chk("running", 16'h0000, {15'h0000, running});
        wr(acir_pkg::ADDR_CTRL, 8'h80);
        for (int k = 0; k < 5; k++) serve(order[k], 16'h0123);
        serve(3'h7, 16'hEC78);
        serve(3'h5, 16'h0123);
        @(negedge clk_i);
        wdog_expire_i = 1'b1;
        @(negedge clk_i);
        wdog_expire_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk("running", 16'h0000, {15'h0000, running});
        rd(acir_pkg::ADDR_CTRL, 8'h00);
        rd(acir_pkg::ADDR_CHAN_OFF, 8'h42);
        rd(acir_pkg::ADDR_RES_HI, 8'hF0);
        rd(acir_pkg::ADDR_RES_LO, 8'h60);
        @(negedge clk_i);
        reg_rst_i = 1'b1;
        @(negedge clk_i);
        reg_rst_i = 1'b0;
        rd(acir_pkg::ADDR_CTRL, 8'h30);
        rd(acir_pkg::ADDR_CHAN_OFF, 8'h00);
        rd(acir_pkg::ADDR_RES_HI, 8'h00);
        rd(acir_pkg::ADDR_RES_LO, 8'h00);
        end_sim();
    end

    // Cuts a hang short
    initial begin
        #500000;
        errors++;
        end_sim();
    end
endmodule
